// >>> shared/cihl_regs.svh
/*
 * Register map, field positions, reset values and timing counts of the
 * interrupt, halt and lock controller.
 * Assumes a 32-bit APB slave with byte addresses on an 8-bit offset.
 */
`ifndef CIHL_REGS_SVH
`define CIHL_REGS_SVH

// ==================================================
// Register offsets
`define CIHL_OFF_CMD     8'h00
`define CIHL_OFF_ADDR    8'h04
`define CIHL_OFF_STATUS  8'h08
`define CIHL_OFF_VECTOR  8'h0C
`define CIHL_OFF_RDATA   8'h10
`define CIHL_OFF_FETCH   8'h14
`define CIHL_OFF_SAVED   8'h18

// ==================================================
// Command bits
`define CIHL_CMD_BOUND   0
`define CIHL_CMD_HALT    1
`define CIHL_CMD_LOCK    2
`define CIHL_CMD_LKEND   3
`define CIHL_CMD_WAIT    4
`define CIHL_CMD_READ    5
`define CIHL_CMD_IRQ_RETURN_INSTR    6
`define CIHL_CMD_STI     7
`define CIHL_CMD_CLI     8

// ==================================================
// Address register field
`define CIHL_ADDR_MEM    20

// ==================================================
// Reset values and vectors
`define CIHL_FETCH_RST   20'hFFFF0
`define CIHL_NMI_TYPE    8'h02
`define CIHL_VEC_HI      12'h000

// ==================================================
// Cycle status codes
`define CIHL_ST_IRQ_ACK_STROBE_N     3'h0
`define CIHL_ST_RD_IO    3'h1
`define CIHL_ST_HALT     3'h3
`define CIHL_ST_RD_MEM   3'h5
`define CIHL_ST_PASSIVE  3'h7

// ==================================================
// Clock counts after reset release
`define CIHL_NMI_ARM     4'h2
`define CIHL_NMI_EARLY   4'h9
`define CIHL_RST_SEQ     4'h7

`endif

// >>> shared/cihl_pkg.sv
/*
 * Types shared by the controller: bus phase and bus cycle kind.
 * Assumes the register header is included by the design file.
 */
`default_nettype none

package cihl_pkg;

	// ==================================================
	// Bus phases
	typedef enum logic [2:0] {
		CIHL_IDLE = 3'b000,
		CIHL_T1   = 3'b001,
		CIHL_T2   = 3'b010,
		CIHL_T3   = 3'b011,
		CIHL_TW   = 3'b100,
		CIHL_T4   = 3'b101
	} cihl_phase_type;

	// ==================================================
	// Bus cycle kinds
	typedef enum logic [1:0] {
		CIHL_K_READ  = 2'b00,
		CIHL_K_INTA1 = 2'b01,
		CIHL_K_INTA2 = 2'b10,
		CIHL_K_HALT  = 2'b11
	} cihl_kind_type;

endpackage

`default_nettype wire

// >>> hdl/cihl_ctrl.sv
/*
 * Interrupt intake, acknowledge sequence, halt, lock, wait-for-test and
 * minimum-mode read cycle of a 16-bit processor's bus unit.
 * Assumes all pins synchronous to SYS_CLK and software driving
 * instruction events through the APB command register.
 */
`include "cihl_regs.svh"
`default_nettype none

module cihl_ctrl (
	// Clock, reset, enable
	input  wire logic        SYS_CLK,
	input  wire logic        RESETN,
	input  wire logic        CLK_EN,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Interrupt and sync inputs
	input  wire logic        NMI,
	input  wire logic        MASK_IRQ_REQ,
	input  wire logic        TEST_N,
	input  wire logic        READY,
	input  wire logic        CONFIG_STRAP,
	// Hold and request/grant
	input  wire logic        HOLD_REQ,
	output logic             HOLD_ACK,
	input  wire logic        REQ_GRANT_IN,
	output logic             REQ_GRANT_OUT,
	// Multiplexed bus
	input  wire logic [15:0] MUXED_ADDR_DATA_I,
	output logic [15:0]      MUXED_ADDR_DATA_O,
	output logic             MUXED_ADDR_DATA_OE,
	output logic [3:0]       ADDR_HI,
	// Bus control
	output logic             ALE,
	output logic             RD_N,
	output logic             IRQ_ACK_STROBE_N,
	output logic             LOCK_N,
	output logic [2:0]       CYCLE_STATUS,
	output logic             MEM_IO,
	output logic             HIGH_BYTE_EN_N,
	output logic             XCVR_DIRECTION,
	output logic             XCVR_ENABLE_N,
	output logic             CTRL_OE
);

	// ==================================================
	// Functions

	function automatic logic [19:0] vec_ptr(input logic [7:0] vtype);
		vec_ptr = {`CIHL_VEC_HI, vtype} << 2;
	endfunction

	function automatic logic in_strobe(input cihl_pkg::cihl_phase_type p);
		in_strobe = (p == cihl_pkg::CIHL_T2) || (p == cihl_pkg::CIHL_T3) || (p == cihl_pkg::CIHL_TW);
	endfunction

	// ==================================================
	// State

	cihl_pkg::cihl_phase_type phase;
	cihl_pkg::cihl_phase_type next_phase;
	cihl_pkg::cihl_kind_type  kind;
	cihl_pkg::cihl_kind_type  next_kind;

	logic        min_mode;
	logic [3:0]  since_rst;
	logic        run;
	logic        nmi_q;
	logic        nmi_pend;
	logic        nmi_skip;
	logic        mask_irq_req_q;
	logic        if_flag;
	logic        saved_if;
	logic [19:0] saved_ret;
	logic        irq_ack_strobe_n_seq;
	logic        irq_ack_strobe_n_lock;
	logic        lock_on;
	logic        lock_end_pend;
	logic        halted;
	logic        halt_pend;
	logic        waiting;
	logic        read_pend;
	logic        rg_req;
	logic [20:0] addr;
	logic [15:0] rdata;
	logic [7:0]  vtype;
	logic [19:0] fetch;
	logic        next_hold;
	logic        hold_rq;

	// ==================================================
	// APB decode

	logic cmd_wr;
	logic wr_acc;
	logic mapped;

	assign PREADY = 1'b1;
	assign wr_acc = PSEL && PENABLE && PWRITE;
	assign cmd_wr = wr_acc && (PADDR == `CIHL_OFF_CMD) && run;

	always_comb begin
		unique case (PADDR)
			`CIHL_OFF_CMD, `CIHL_OFF_ADDR, `CIHL_OFF_STATUS, `CIHL_OFF_VECTOR,
			`CIHL_OFF_RDATA, `CIHL_OFF_FETCH, `CIHL_OFF_SAVED: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	assign PSLVERR = PSEL && PENABLE && !mapped;

	// Read data is registered in the setup phase so it is stable in access.
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			PRDATA <= 32'h0000_0000;
		end else if (CLK_EN && PSEL && !PENABLE) begin
			unique case (PADDR)
				`CIHL_OFF_ADDR:   PRDATA <= {11'h000, addr};
				`CIHL_OFF_STATUS: PRDATA <= {20'h00000, run, min_mode, irq_ack_strobe_n_seq, HOLD_ACK,
					nmi_pend, read_pend, lock_on, waiting, halted, if_flag, phase != cihl_pkg::CIHL_IDLE, 1'b0};
				`CIHL_OFF_VECTOR: PRDATA <= {24'h000000, vtype};
				`CIHL_OFF_RDATA:  PRDATA <= {16'h0000, rdata};
				`CIHL_OFF_FETCH:  PRDATA <= {12'h000, fetch};
				`CIHL_OFF_SAVED:  PRDATA <= {11'h000, saved_if, saved_ret};
				default:          PRDATA <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			addr <= 21'h000000;
		end else if (CLK_EN && wr_acc && PADDR == `CIHL_OFF_ADDR) begin
			addr <= PWDATA[20:0];
		end
	end

	// ==================================================
	// Reset sequence and strap capture

	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			since_rst <= 4'h0;
			min_mode  <= 1'b1;
		end else if (CLK_EN) begin
			if (since_rst == 4'h0) begin
				min_mode <= CONFIG_STRAP;
			end
			if (since_rst != `CIHL_NMI_EARLY) begin
				since_rst <= since_rst + 4'h1;
			end
		end
	end

	assign run = since_rst >= `CIHL_RST_SEQ;

	// ==================================================
	// Interrupt intake

	logic nmi_edge;
	logic bound;
	logic take_ok;
	logic take_nmi;
	logic take_int;
	logic bus_idle;

	assign bus_idle = (phase == cihl_pkg::CIHL_IDLE) && !irq_ack_strobe_n_seq && !HOLD_ACK;
	assign nmi_edge = NMI && !nmi_q && (since_rst >= `CIHL_NMI_ARM);
	assign bound    = (cmd_wr && PWDATA[`CIHL_CMD_BOUND]) || halted || waiting;
	assign take_ok  = run && bound && bus_idle && !halt_pend;
	assign take_nmi = take_ok && nmi_pend && !nmi_skip;
	assign take_int = take_ok && !(nmi_pend && !nmi_skip) && if_flag && mask_irq_req_q;

	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			nmi_q  <= 1'b0;
			mask_irq_req_q <= 1'b0;
		end else if (CLK_EN) begin
			nmi_q  <= NMI;
			mask_irq_req_q <= MASK_IRQ_REQ;
		end
	end

	// A new edge in the service cycle stays pending: the set wins.
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			nmi_pend <= 1'b0;
			nmi_skip <= 1'b0;
		end else if (CLK_EN) begin
			if (nmi_edge) begin
				nmi_pend <= 1'b1;
			end else if (take_nmi) begin
				nmi_pend <= 1'b0;
			end
			if (nmi_edge && since_rst < `CIHL_NMI_EARLY) begin
				nmi_skip <= 1'b1;
			end else if (take_ok && nmi_pend) begin
				nmi_skip <= 1'b0;
			end
		end
	end

	// Enable flag and saved context.
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			if_flag   <= 1'b0;
			saved_if  <= 1'b0;
			saved_ret <= 20'h00000;
		end else if (CLK_EN) begin
			if (take_nmi || take_int) begin
				saved_if  <= if_flag;
				saved_ret <= fetch;
				if_flag   <= 1'b0;
			end else if (cmd_wr && PWDATA[`CIHL_CMD_IRQ_RETURN_INSTR]) begin
				if_flag <= saved_if;
			end else if (cmd_wr && PWDATA[`CIHL_CMD_STI]) begin
				if_flag <= 1'b1;
			end else if (cmd_wr && PWDATA[`CIHL_CMD_CLI]) begin
				if_flag <= 1'b0;
			end
		end
	end

	// Vector and fetch pointer.
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			vtype <= 8'h00;
			fetch <= `CIHL_FETCH_RST;
		end else if (CLK_EN) begin
			if (take_nmi) begin
				vtype <= `CIHL_NMI_TYPE;
				fetch <= vec_ptr(`CIHL_NMI_TYPE);
			end else if (cmd_wr && PWDATA[`CIHL_CMD_IRQ_RETURN_INSTR]) begin
				fetch <= saved_ret;
			end else if (phase == cihl_pkg::CIHL_T4 && kind == cihl_pkg::CIHL_K_INTA2) begin
				vtype <= rdata[7:0];
				fetch <= vec_ptr(rdata[7:0]);
			end
		end
	end

	// The acknowledge pair is one indivisible sequence.
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			irq_ack_strobe_n_seq <= 1'b0;
		end else if (CLK_EN) begin
			if (take_int) begin
				irq_ack_strobe_n_seq <= 1'b1;
			end else if (phase == cihl_pkg::CIHL_T4 && kind == cihl_pkg::CIHL_K_INTA2) begin
				irq_ack_strobe_n_seq <= 1'b0;
			end
		end
	end

	// ==================================================
	// Halt, wait and read requests

	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			halted    <= 1'b0;
			halt_pend <= 1'b0;
			waiting   <= 1'b0;
			read_pend <= 1'b0;
		end else if (CLK_EN) begin
			if (cmd_wr && PWDATA[`CIHL_CMD_HALT]) begin
				halt_pend <= 1'b1;
			end else if (HOLD_ACK && !next_hold && halted) begin
				halt_pend <= 1'b1;
			end else if (next_phase == cihl_pkg::CIHL_T1 && next_kind == cihl_pkg::CIHL_K_HALT) begin
				halt_pend <= 1'b0;
			end
			if (phase == cihl_pkg::CIHL_T1 && kind == cihl_pkg::CIHL_K_HALT) begin
				halted <= 1'b1;
			end else if (take_nmi || take_int) begin
				halted <= 1'b0;
			end
			if (cmd_wr && PWDATA[`CIHL_CMD_WAIT]) begin
				waiting <= 1'b1;
			end else if (!TEST_N && !HOLD_ACK) begin
				waiting <= 1'b0;
			end
			if (cmd_wr && PWDATA[`CIHL_CMD_READ]) begin
				read_pend <= 1'b1;
			end else if (next_phase == cihl_pkg::CIHL_T1 && next_kind == cihl_pkg::CIHL_K_READ) begin
				read_pend <= 1'b0;
			end
		end
	end

	// ==================================================
	// Bus hold and request/grant

	assign hold_rq = min_mode ? HOLD_REQ : rg_req;
	// Lock and the acknowledge pair keep the bus; the request waits.
	always_comb begin
		next_hold = HOLD_ACK;
		if (!HOLD_ACK && hold_rq && bus_idle && !lock_on && !take_int) begin
			next_hold = 1'b1;
		end else if (HOLD_ACK && !hold_rq) begin
			next_hold = 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			rg_req        <= 1'b0;
			HOLD_ACK      <= 1'b0;
			REQ_GRANT_OUT <= 1'b0;
			CTRL_OE       <= 1'b1;
		end else if (CLK_EN) begin
			if (REQ_GRANT_IN && !min_mode) begin
				rg_req <= !rg_req;
			end
			HOLD_ACK      <= next_hold;
			REQ_GRANT_OUT <= !min_mode && next_hold && !HOLD_ACK;
			CTRL_OE       <= !next_hold;
		end
	end

	// ==================================================
	// Lock

	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			lock_on       <= 1'b0;
			lock_end_pend <= 1'b0;
			irq_ack_strobe_n_lock     <= 1'b0;
		end else if (CLK_EN) begin
			if (cmd_wr && PWDATA[`CIHL_CMD_LOCK]) begin
				lock_on       <= 1'b1;
				lock_end_pend <= 1'b0;
			end else if (lock_end_pend && (phase == cihl_pkg::CIHL_T4 ||
					(phase == cihl_pkg::CIHL_IDLE && !read_pend))) begin
				lock_on       <= 1'b0;
				lock_end_pend <= 1'b0;
			end else if (cmd_wr && PWDATA[`CIHL_CMD_LKEND]) begin
				lock_end_pend <= 1'b1;
			end
			if (next_phase == cihl_pkg::CIHL_T2 && phase == cihl_pkg::CIHL_T1) begin
				if (kind == cihl_pkg::CIHL_K_INTA1) begin
					irq_ack_strobe_n_lock <= 1'b1;
				end else if (kind == cihl_pkg::CIHL_K_INTA2) begin
					irq_ack_strobe_n_lock <= 1'b0;
				end
			end
		end
	end

	// ==================================================
	// Bus cycle sequencer

	always_comb begin
		next_phase = phase;
		next_kind  = kind;
		unique case (phase)
			cihl_pkg::CIHL_IDLE: begin
				if (irq_ack_strobe_n_seq && kind == cihl_pkg::CIHL_K_INTA1) begin
					next_phase = cihl_pkg::CIHL_T1;
					next_kind  = cihl_pkg::CIHL_K_INTA2;
				end else if (take_int) begin
					next_phase = cihl_pkg::CIHL_T1;
					next_kind  = cihl_pkg::CIHL_K_INTA1;
				end else if (run && !HOLD_ACK && !next_hold && read_pend) begin
					next_phase = cihl_pkg::CIHL_T1;
					next_kind  = cihl_pkg::CIHL_K_READ;
				end else if (run && !HOLD_ACK && !next_hold && halt_pend) begin
					next_phase = cihl_pkg::CIHL_T1;
					next_kind  = cihl_pkg::CIHL_K_HALT;
				end
			end
			cihl_pkg::CIHL_T1: begin
				next_phase = (kind == cihl_pkg::CIHL_K_HALT) ? cihl_pkg::CIHL_IDLE : cihl_pkg::CIHL_T2;
			end
			cihl_pkg::CIHL_T2: next_phase = cihl_pkg::CIHL_T3;
			cihl_pkg::CIHL_T3, cihl_pkg::CIHL_TW: begin
				next_phase = READY ? cihl_pkg::CIHL_T4 : cihl_pkg::CIHL_TW;
			end
			cihl_pkg::CIHL_T4: next_phase = cihl_pkg::CIHL_IDLE;
			default: next_phase = cihl_pkg::CIHL_IDLE;
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			phase <= cihl_pkg::CIHL_IDLE;
			kind  <= cihl_pkg::CIHL_K_READ;
		end else if (CLK_EN) begin
			phase <= next_phase;
			kind  <= next_kind;
		end
	end

	// Data is taken on the edge that leaves t3 or a wait state with ready.
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			rdata <= 16'h0000;
		end else if (CLK_EN && in_strobe(phase) && phase != cihl_pkg::CIHL_T2 && READY) begin
			rdata <= MUXED_ADDR_DATA_I;
		end
	end

	// ==================================================
	// Pin outputs, registered from the next phase

	logic strobe_nx;
	logic cyc_nx;
	logic rd_kind;
	logic ack_kind;

	assign strobe_nx = in_strobe(next_phase);
	assign cyc_nx    = next_phase != cihl_pkg::CIHL_IDLE;
	assign rd_kind   = next_kind == cihl_pkg::CIHL_K_READ;
	assign ack_kind  = (next_kind == cihl_pkg::CIHL_K_INTA1) || (next_kind == cihl_pkg::CIHL_K_INTA2);

	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			ALE                <= 1'b0;
			RD_N               <= 1'b1;
			IRQ_ACK_STROBE_N   <= 1'b1;
			LOCK_N             <= 1'b1;
			CYCLE_STATUS       <= `CIHL_ST_PASSIVE;
			MEM_IO             <= 1'b0;
			HIGH_BYTE_EN_N     <= 1'b1;
			XCVR_DIRECTION     <= 1'b1;
			XCVR_ENABLE_N      <= 1'b1;
			MUXED_ADDR_DATA_O  <= 16'h0000;
			MUXED_ADDR_DATA_OE <= 1'b0;
			ADDR_HI            <= 4'h0;
		end else if (CLK_EN) begin
			ALE  <= min_mode && next_phase == cihl_pkg::CIHL_T1;
			RD_N <= !(min_mode && strobe_nx && rd_kind);
			IRQ_ACK_STROBE_N <= !(min_mode && strobe_nx && ack_kind);
			// In minimum mode this pin carries the unused write strobe.
			LOCK_N <= min_mode || !(lock_on || irq_ack_strobe_n_lock);
			if (min_mode || !cyc_nx || next_phase == cihl_pkg::CIHL_T4) begin
				CYCLE_STATUS <= `CIHL_ST_PASSIVE;
			end else if (next_kind == cihl_pkg::CIHL_K_HALT) begin
				CYCLE_STATUS <= `CIHL_ST_HALT;
			end else if (ack_kind) begin
				CYCLE_STATUS <= `CIHL_ST_IRQ_ACK_STROBE_N;
			end else begin
				CYCLE_STATUS <= addr[`CIHL_ADDR_MEM] ? `CIHL_ST_RD_MEM : `CIHL_ST_RD_IO;
			end
			if (next_phase == cihl_pkg::CIHL_T1) begin
				MEM_IO <= rd_kind && addr[`CIHL_ADDR_MEM];
			end
			HIGH_BYTE_EN_N <= !(cyc_nx && rd_kind);
			XCVR_DIRECTION <= !(cyc_nx && (rd_kind || ack_kind));
			XCVR_ENABLE_N  <= !((strobe_nx || next_phase == cihl_pkg::CIHL_T4) && next_kind != cihl_pkg::CIHL_K_HALT);
			// Acknowledge cycles leave the bus undriven.
			MUXED_ADDR_DATA_OE <= next_phase == cihl_pkg::CIHL_T1 && (rd_kind || next_kind == cihl_pkg::CIHL_K_HALT);
			if (next_phase == cihl_pkg::CIHL_T1 && rd_kind) begin
				MUXED_ADDR_DATA_O <= addr[15:0];
				ADDR_HI           <= addr[`CIHL_ADDR_MEM] ? addr[19:16] : 4'h0;
			end
		end
	end

endmodule

`default_nettype wire

// >>> verif/cihl_ctrl_monitor.sv
/*
 * Concurrent checks on the bus-cycle pins of the controller.
 * Assumes the strap only changes while reset is held.
 */
`default_nettype none

module cihl_ctrl_monitor (
	// Watched pins
	input wire logic SYS_CLK,
	input wire logic RESETN,
	input wire logic READY,
	input wire logic CONFIG_STRAP,
	input wire logic ALE,
	input wire logic RD_N,
	input wire logic IRQ_ACK_STROBE_N,
	input wire logic LOCK_N,
	input wire logic MEM_IO,
	input wire logic HOLD_ACK,
	input wire logic CTRL_OE,
	input wire logic MUXED_ADDR_DATA_OE,
	input wire logic HIGH_BYTE_EN_N,
	input wire logic XCVR_DIRECTION,
	input wire logic XCVR_ENABLE_N
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESETN);

	// ========================================
	// Bus cycle shape
	ale_one_a: assert property (ALE |=> !ALE) else $error("latch pulse longer than one cycle");
	rd_after_ale_a: assert property ($fell(RD_N) |-> $past(ALE) && !MUXED_ADDR_DATA_OE)
		else $error("read strobe without latch pulse or with address out");
	space_held_a: assert property (!RD_N |-> $stable(MEM_IO)) else $error("space flag moved in read");
	xcvr_read_a: assert property (!RD_N |-> !XCVR_ENABLE_N && !XCVR_DIRECTION && !HIGH_BYTE_EN_N)
		else $error("transceiver or byte enable not set for read");
	rd_len_a: assert property ($fell(RD_N) |=> !RD_N) else $error("read strobe shorter than t2 t3");
	rd_ready_a: assert property ($rose(RD_N) |-> $past(READY)) else $error("read ended while not ready");
	ack_ale_a: assert property ($fell(IRQ_ACK_STROBE_N) |-> $past(ALE) && RD_N)
		else $error("acknowledge strobe out of place");

	// ========================================
	// Lock and hold
	lock_min_a: assert property (CONFIG_STRAP |-> LOCK_N) else $error("lock driven in minimum mode");
	ack_hold_a: assert property (!IRQ_ACK_STROBE_N |-> !HOLD_ACK) else $error("hold granted in ack");
	hold_float_a: assert property (HOLD_ACK && $past(HOLD_ACK) |-> !CTRL_OE)
		else $error("outputs driven during hold");
endmodule

bind cihl_ctrl cihl_ctrl_monitor i_cihl_ctrl_monitor (.SYS_CLK, .RESETN, .READY, .CONFIG_STRAP, .ALE,
	.RD_N, .IRQ_ACK_STROBE_N, .LOCK_N, .MEM_IO, .HOLD_ACK, .CTRL_OE, .MUXED_ADDR_DATA_OE, .HIGH_BYTE_EN_N,
	.XCVR_DIRECTION, .XCVR_ENABLE_N);

`default_nettype wire

// >>> verif/cihl_partner.sv
/*
 * Memory and interrupt controller model on the multiplexed bus.
 * Assumes the controller's strobes and latch pulse are registered.
 */
`default_nettype none

module cihl_partner (
	// Controller side
	input  wire logic        sys_clk,
	input  wire logic        ale,
	input  wire logic        rd_n,
	input  wire logic        ack_n,
	input  wire logic [15:0] addr,
	// Bench settings
	input  wire logic [1:0]  wait_n,
	input  wire logic [7:0]  irq_type,
	// Answer
	output logic [15:0]      data,
	output logic             ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] lat = 16'h0000;
	logic [15:0] last = 16'h0000;
	logic [3:0]  cnt = 4'h0;
	wire logic   strobe = !rd_n || !ack_n;

	always_ff @(posedge sys_clk) begin
		if (ale) lat <= addr;
		cnt <= strobe ? cnt + 4'h1 : 4'h0;
		last <= data;
	end
	// Data stands only with ready; otherwise the bus toggles so an early sample cannot pass.
	assign data = ready ? (!rd_n ? lat ^ 16'hA5A5 : {8'hC3, irq_type}) : ~last;
	assign ready = strobe && cnt >= {2'h0, wait_n} + 4'h1;
endmodule

`default_nettype wire

// >>> verif/cihl_ctrl_tb_top.sv
/*
 * Self-checking bench of the controller: register rows, then cycles.
 * Assumes the partner model answers reads and acknowledges.
 */
`include "cihl_regs.svh"
`default_nettype none

module cihl_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] exp; logic err;} cihl_row_type;
	logic        sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rv;
	logic        nmi = 1'b0, irq = 1'b0, test_n = 1'b1, strap = 1'b1, hold_req = 1'b0, rg_in = 1'b0, se;
	logic [1:0]  wait_n = 2'h0;
	wire logic [31:0] prdata;
	wire logic [15:0] mad_o, mad_i;
	wire logic [2:0]  cyc_st;
	wire logic [3:0]  addr_hi;
	wire logic        pready, pslverr, hold_ack, rg_out, mad_oe, ale, rd_n, ack_n, lock_n, mem_io, ready, ctrl_oe;
	int          fail_count = 0, checks = 0, cyc = 0, rdlo = 0, acklo = 0, ales = 0, grants = 0, sawh = 0;
	cihl_row_type rows [5] = '{'{1'b0, `CIHL_OFF_FETCH, 32'h0, 32'h000FFFF0, 1'b0},
		'{1'b1, `CIHL_OFF_ADDR, 32'h00112344, 32'h0, 1'b0}, '{1'b0, `CIHL_OFF_ADDR, 32'h0, 32'h00112344, 1'b0},
		'{1'b0, 8'h1C, 32'h0, 32'h0, 1'b1}, '{1'b1, 8'h20, 32'h5, 32'h0, 1'b1}};

	cihl_ctrl i_cihl_ctrl (.SYS_CLK(sys_clk), .RESETN(resetn), .CLK_EN(1'b1), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.NMI(nmi), .MASK_IRQ_REQ(irq), .TEST_N(test_n), .READY(ready), .CONFIG_STRAP(strap),
		.HOLD_REQ(hold_req), .HOLD_ACK(hold_ack), .REQ_GRANT_IN(rg_in), .REQ_GRANT_OUT(rg_out),
		.MUXED_ADDR_DATA_I(mad_i), .MUXED_ADDR_DATA_O(mad_o), .MUXED_ADDR_DATA_OE(mad_oe), .ADDR_HI(addr_hi),
		.ALE(ale), .RD_N(rd_n), .IRQ_ACK_STROBE_N(ack_n), .LOCK_N(lock_n), .CYCLE_STATUS(cyc_st),
		.MEM_IO(mem_io), .HIGH_BYTE_EN_N(), .XCVR_DIRECTION(), .XCVR_ENABLE_N(), .CTRL_OE(ctrl_oe));
	cihl_partner i_cihl_partner (.sys_clk(sys_clk), .ale(ale), .rd_n(rd_n), .ack_n(ack_n), .addr(mad_o),
		.wait_n(wait_n), .irq_type(8'h4B), .data(mad_i), .ready(ready));

	initial forever #4 sys_clk = ~sys_clk;

	// ========================================
	// Event counters and hang guard
	always @(posedge sys_clk) begin
		cyc++;
		rdlo += !rd_n;
		acklo += !ack_n;
		ales += ale;
		grants += rg_out;
		sawh += (cyc_st === `CIHL_ST_HALT);
		if (cyc == 30000) begin
			fail_count++;
			wrap_up();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Read data and error are taken at the completing edge, where pready is seen high.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rv = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic cmd(input int b);
		apb(1'b1, `CIHL_OFF_CMD, 32'h1 << b);
	endtask

	task automatic poll(input int b, input logic v);
		int k;
		k = 0;
		do begin
			apb(1'b0, `CIHL_OFF_STATUS, 32'h0);
			k++;
		end while (rv[b] !== v && k < 40);
		chk("status bit", {31'h0, v}, {31'h0, rv[b]});
	endtask

	task automatic reg_is(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk("register", exp, rv);
	endtask

	task automatic nmi_pulse();
		nmi <= 1'b1;
		repeat (3) @(posedge sys_clk);
		nmi <= 1'b0;
	endtask

	task automatic wrap_up();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (10) @(posedge sys_clk);
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].a, rows[i].d);
			if (!rows[i].wr) chk("rdata", rows[i].exp, rv);
			chk("slverr", {31'h0, rows[i].err}, {31'h0, se});
		end
		for (int w = 0; w < 4; w++) begin
			wait_n <= w[1:0];
			rdlo = 0;
			apb(1'b1, `CIHL_OFF_ADDR, 32'h00112344 + 32'(w));
			cmd(`CIHL_CMD_READ);
			poll(1, 1'b0);
			reg_is(`CIHL_OFF_RDATA, (32'h00002344 + 32'(w)) ^ 32'h0000A5A5);
			chk("strobe cycles", 32'(w + 2), 32'(rdlo));
			chk("upper address", 32'h1, {28'h0, addr_hi});
			chk("space flag", 32'h1, {31'h0, mem_io});
		end
		wait_n <= 2'h0;
		irq <= 1'b1;
		acklo = 0;
		cmd(`CIHL_CMD_BOUND);
		repeat (12) @(posedge sys_clk);
		chk("masked ack", 32'h0, 32'(acklo));
		cmd(`CIHL_CMD_STI);
		cmd(`CIHL_CMD_BOUND);
		for (int k = 0; k < 40 && ack_n !== 1'b0; k++) @(posedge sys_clk);
		irq <= 1'b0;
		hold_req <= 1'b1;
		poll(9, 1'b0);
		poll(8, 1'b1);
		hold_req <= 1'b0;
		poll(8, 1'b0);
		chk("ack cycles", 32'h4, 32'(acklo));
		reg_is(`CIHL_OFF_VECTOR, 32'h4B);
		reg_is(`CIHL_OFF_FETCH, 32'h12C);
		poll(2, 1'b0);
		apb(1'b0, `CIHL_OFF_SAVED, 32'h0);
		chk("saved flag", 32'h1, {31'h0, rv[20]});
		cmd(`CIHL_CMD_IRQ_RETURN_INSTR);
		poll(2, 1'b1);
		irq <= 1'b1;
		acklo = 0;
		for (int k = 0; k < 2; k++) begin
			nmi_pulse();
			poll(7, 1'b1);
			cmd(`CIHL_CMD_BOUND);
			poll(7, 1'b0);
			reg_is(`CIHL_OFF_FETCH, 32'h8);
		end
		irq <= 1'b0;
		chk("nmi bus cycles", 32'h0, 32'(acklo));
		poll(2, 1'b0);
		ales = 0;
		rdlo = 0;
		cmd(`CIHL_CMD_HALT);
		poll(3, 1'b1);
		chk("halt pulses", 32'h1, 32'(ales + rdlo));
		hold_req <= 1'b1;
		poll(8, 1'b1);
		hold_req <= 1'b0;
		poll(8, 1'b0);
		repeat (4) @(posedge sys_clk);
		chk("halt reissued", 32'h2, 32'(ales));
		poll(3, 1'b1);
		nmi_pulse();
		poll(3, 1'b0);
		ales = 0;
		cmd(`CIHL_CMD_WAIT);
		poll(4, 1'b1);
		repeat (10) @(posedge sys_clk);
		chk("wait bus cycles", 32'h0, 32'(ales));
		test_n <= 1'b0;
		poll(4, 1'b0);
		resetn <= 1'b0;
		strap <= 1'b0;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		nmi <= 1'b1;
		repeat (12) @(posedge sys_clk);
		nmi <= 1'b0;
		poll(7, 1'b0);
		cmd(`CIHL_CMD_LOCK);
		poll(5, 1'b1);
		chk("lock pin", 32'h0, {31'h0, lock_n});
		grants = 0;
		rg_in <= 1'b1;
		@(posedge sys_clk);
		rg_in <= 1'b0;
		repeat (6) @(posedge sys_clk);
		chk("grant in lock", 32'h0, 32'(grants));
		cmd(`CIHL_CMD_LKEND);
		repeat (6) @(posedge sys_clk);
		chk("lock pin", 32'h1, {31'h0, lock_n});
		chk("grant after lock", 32'h1, 32'(grants));
		rg_in <= 1'b1;
		@(posedge sys_clk);
		rg_in <= 1'b0;
		repeat (4) @(posedge sys_clk);
		sawh = 0;
		cmd(`CIHL_CMD_HALT);
		poll(3, 1'b1);
		chk("halt status", 32'h1, 32'(sawh > 0));
		wrap_up();
	end
endmodule

`default_nettype wire
